// ===== hdl/ccl_axi_slave.sv
// module: axi4-lite slave front end producing register strobes
`timescale 1ns/100ps
module ccl_axi_slave (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // write channels
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read address
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    input wire logic rready,
    input wire logic rvalid,
    // register side
    ccl_reg_if.slave regs
);
    import ccl_pkg::*;
    logic awHeld;
    logic wHeld;
    logic [7:0] awAddrQ;
    logic [7:0] wDataQ;
    logic wLaneQ;
    ccl_wstate_t wState;
    wire awTake = awvalid && awready;
    wire wTake = wvalid && wready;
    wire haveAw = awHeld || awTake;
    wire haveW = wHeld || wTake;
    wire doWrite = (wState == W_IDLE) && haveAw && haveW;
    wire [7:0] curAddr = awTake ? awaddr : awAddrQ;
    wire [7:0] curData = wTake ? wdata[7:0] : wDataQ;
    wire curLane = wTake ? wstrb[0] : wLaneQ;
    // only the low byte lane carries register data; upper lanes read zero anyway
    assign regs.wrEn = doWrite && curLane;
    assign regs.wrAddr = curAddr;
    assign regs.wrData = curData;
    assign regs.rdEn = arvalid && arready;
    assign regs.rdAddr = araddr;
    // read side takes one address at a time; a leaving answer frees it
    wire rdTake = arvalid && arready;
    // address and data latched independently, in either order
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrQ <= 8'h00;
            wDataQ <= 8'h00;
            wLaneQ <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            arready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            wState <= W_IDLE;
        end else begin
            awready <= !haveAw && (wState == W_IDLE);
            wready <= !haveW && (wState == W_IDLE);
            arready <= !(rdTake || (rvalid && !rready));
            if (awTake) begin
                awAddrQ <= awaddr;
            end
            if (wTake) begin
                wDataQ <= wdata[7:0];
                wLaneQ <= wstrb[0];
            end
            case (wState)
                W_IDLE: begin
                    if (doWrite) begin
                        awHeld <= 1'b0;
                        wHeld <= 1'b0;
                        awready <= 1'b0;
                        wready <= 1'b0;
                        bvalid <= 1'b1;
                        bresp <= (curAddr > ADDR_VECTOR_ACK || curAddr[1:0] != 2'b00)
                            ? RESP_SLVERR : RESP_OKAY;
                        wState <= W_RESP;
                    end else begin
                        awHeld <= haveAw;
                        wHeld <= haveW;
                    end
                end
                W_RESP: begin
                    awready <= 1'b0;
                    wready <= 1'b0;
                    if (bready) begin
                        bvalid <= 1'b0;
                        wState <= W_IDLE;
                    end
                end
                default: wState <= W_IDLE;
            endcase
        end
    end
endmodule : ccl_axi_slave

// ===== hdl/ccl_pkg.sv
// package: register map, field positions, reset values and modes of the comparator control
package ccl_pkg;
    // register byte offsets (word aligned)
    localparam logic [7:0] ADDR_CMP_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CONV_CTRL_B = 8'h04;
    localparam logic [7:0] ADDR_BUF_DISABLE = 8'h08;
    localparam logic [7:0] ADDR_CONV_CTRL_A = 8'h0C;
    localparam logic [7:0] ADDR_GLOBAL = 8'h10;
    localparam logic [7:0] ADDR_VECTOR_ACK = 8'h14;
    // comparator_control_status fields
    localparam int BIT_POWER_OFF = 7;
    localparam int BIT_BANDGAP = 6;
    localparam int BIT_RESULT = 5;
    localparam int BIT_EVENT_FLAG = 4;
    localparam int BIT_IRQ_EN = 3;
    localparam int BIT_CAPTURE = 2;
    localparam int BIT_MODE_HI = 1;
    localparam int BIT_MODE_LO = 0;
    // converter_control_b field
    localparam int BIT_NEG_MUX_EN = 6;
    // input_buffer_disable_1 fields
    localparam int BIT_NEG_BUF_OFF = 1;
    localparam int BIT_POS_BUF_OFF = 0;
    // converter_control_a (own): enable, power reduction, channel select
    localparam int BIT_CONV_EN = 7;
    localparam int BIT_CONV_PWR_RED = 6;
    localparam int LSB_CHANNEL = 0;
    // global register (own)
    localparam int BIT_GLOBAL_IRQ = 0;
    // reset values
    localparam logic [7:0] RST_CMP_CTRL = 8'h00;
    localparam logic [7:0] RST_CONV_CTRL_B = 8'h00;
    localparam logic [7:0] RST_BUF_DISABLE = 8'h00;
    localparam logic [7:0] RST_CONV_CTRL_A = 8'h00;
    // event modes
    localparam logic [1:0] MODE_TOGGLE = 2'h0;
    localparam logic [1:0] MODE_RESERVED = 2'h1;
    localparam logic [1:0] MODE_FALL = 2'h2;
    localparam logic [1:0] MODE_RISE = 2'h3;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // register write port state
    typedef enum logic [1:0] {
        W_IDLE,
        W_RESP
    } ccl_wstate_t;
endpackage : ccl_pkg

// ===== hdl/ccl_reg_if.sv
// interface: register write strobe and data, plus read strobe and address, from the bus slave to the register file
`timescale 1ns/100ps
interface ccl_reg_if;
    logic wrEn;
    logic [7:0] wrAddr;
    logic [7:0] wrData;
    logic rdEn;
    logic [7:0] rdAddr;
    modport slave (output wrEn, output wrAddr, output wrData, output rdEn, output rdAddr);
    modport regs (input wrEn, input wrAddr, input wrData, input rdEn, input rdAddr);
endinterface : ccl_reg_if

// ===== hdl/ccl_top.sv
// module: comparator control logic top with axi4-lite registers and analog routing
// ============================================================
// Summary of operation
// - comparator output double-flopped into result bit
// - mode 00 toggle, 01 none, 10 fall, 11 rise
// - flag set on selected edge, always
// - irq only when flag, enable, global all set
// - flag cleared when handler vector taken
// - write one clears flag, zero keeps
// - power-off bit removes comparator power
// - bandgap replaces positive input when selected
// - capture route connects output to timer
// - mux picks pin N when enabled, converter off
// - buffer-off disables pin buffer, reads zero
// - converter enable turns converter on
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
module ccl_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // analog comparator interface
    input wire logic comparatorRaw,
    output logic comparatorPowerOff,
    output logic bandgapSelect,
    output logic [3:0] negativeSource,
    output logic converterEnable,
    output logic converterPowerReduction,
    // pins and system
    input wire logic positiveInputPin,
    input wire logic negativeInputPin,
    output logic positivePinDigital,
    output logic negativePinDigital,
    output logic positiveBufferOff,
    output logic negativeBufferOff,
    output logic captureInput,
    output logic comparatorIrq,
    input wire logic vectorTaken
);
    import ccl_pkg::*;

    // ============================================================
    // bus slave
    ccl_reg_if regBus ();
    logic arReadyInt;
    logic awReadyInt;
    logic wReadyInt;
    ccl_axi_slave u_slave (
        .sys_clk(sys_clk),
        .rst(rst),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(awReadyInt),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(wReadyInt),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(arReadyInt),
        .rready(s_axi_rready),
        .rvalid(s_axi_rvalid),
        .regs(regBus.slave)
    );
    assign s_axi_awready = awReadyInt;
    assign s_axi_wready = wReadyInt;
    assign s_axi_arready = arReadyInt;

    // ============================================================
    // registers
    logic [7:0] cmpCtrl;
    logic [7:0] convCtrlB;
    logic [7:0] bufDisable;
    logic [7:0] convCtrlA;
    logic globalIrqEnable;
    logic eventFlag;

    wire wrCmp = regBus.wrEn && regBus.wrAddr == ADDR_CMP_CTRL;
    wire wrConvB = regBus.wrEn && regBus.wrAddr == ADDR_CONV_CTRL_B;
    wire wrBuf = regBus.wrEn && regBus.wrAddr == ADDR_BUF_DISABLE;
    wire wrConvA = regBus.wrEn && regBus.wrAddr == ADDR_CONV_CTRL_A;
    wire wrGlobal = regBus.wrEn && regBus.wrAddr == ADDR_GLOBAL;
    wire wrVector = regBus.wrEn && regBus.wrAddr == ADDR_VECTOR_ACK;

    wire [1:0] modeSel = {cmpCtrl[BIT_MODE_HI], cmpCtrl[BIT_MODE_LO]};
    wire irqEnable = cmpCtrl[BIT_IRQ_EN];
    wire negMuxEnable = convCtrlB[BIT_NEG_MUX_EN];
    wire convEnable = convCtrlA[BIT_CONV_EN];
    wire [2:0] channelSel = convCtrlA[LSB_CHANNEL +: 3];

    // flag and result bits are hardware-owned, so they never store write data
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cmpCtrl <= RST_CMP_CTRL;
            convCtrlB <= RST_CONV_CTRL_B;
            bufDisable <= RST_BUF_DISABLE;
            convCtrlA <= RST_CONV_CTRL_A;
            globalIrqEnable <= 1'b0;
        end else begin
            if (wrCmp) begin
                cmpCtrl <= regBus.wrData & 8'hCF;
            end
            if (wrConvB) begin
                convCtrlB <= regBus.wrData & 8'h40;
            end
            if (wrBuf) begin
                bufDisable <= regBus.wrData & 8'h03;
            end
            if (wrConvA) begin
                convCtrlA <= regBus.wrData & 8'hC7;
            end
            if (wrGlobal) begin
                globalIrqEnable <= regBus.wrData[BIT_GLOBAL_IRQ];
            end
        end
    end

    // ============================================================
    // comparator synchroniser and edge detection
    logic syncFirst;
    logic syncResult;
    logic prevResult;
    // first stage feeds only the second stage
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            syncFirst <= 1'b0;
            syncResult <= 1'b0;
            prevResult <= 1'b0;
        end else begin
            syncFirst <= comparatorRaw;
            syncResult <= syncFirst;
            prevResult <= syncResult;
        end
    end

    wire riseEdge = syncResult && !prevResult;
    wire fallEdge = !syncResult && prevResult;
    // the reserved code raises no event at all
    wire edgeEvent = (modeSel == MODE_TOGGLE && (riseEdge || fallEdge))
        || (modeSel == MODE_FALL && fallEdge)
        || (modeSel == MODE_RISE && riseEdge);

    // clear sources: vector pulse or write, or write-one; a coincident event wins
    wire flagClear = wrVector || vectorTaken || (wrCmp && regBus.wrData[BIT_EVENT_FLAG]);
    wire next_eventFlag = edgeEvent ? 1'b1 : (flagClear ? 1'b0 : eventFlag);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            eventFlag <= 1'b0;
        end else begin
            eventFlag <= next_eventFlag;
        end
    end

    // ============================================================
    // outputs to analog, timer and pins, all registered
    wire useMux = negMuxEnable && !convEnable;
    wire [3:0] next_negSource = useMux ? {1'b1, channelSel} : 4'h0;
    wire irqNow = eventFlag && irqEnable && globalIrqEnable;
    logic posPinSync1;
    logic posPinSync2;
    logic negPinSync1;
    logic negPinSync2;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            comparatorPowerOff <= 1'b0;
            bandgapSelect <= 1'b0;
            negativeSource <= 4'h0;
            converterEnable <= 1'b0;
            converterPowerReduction <= 1'b0;
            captureInput <= 1'b0;
            comparatorIrq <= 1'b0;
            positiveBufferOff <= 1'b0;
            negativeBufferOff <= 1'b0;
        end else begin
            comparatorPowerOff <= cmpCtrl[BIT_POWER_OFF];
            bandgapSelect <= cmpCtrl[BIT_BANDGAP];
            negativeSource <= next_negSource;
            converterEnable <= convEnable;
            converterPowerReduction <= convCtrlA[BIT_CONV_PWR_RED];
            captureInput <= cmpCtrl[BIT_CAPTURE] && syncResult;
            comparatorIrq <= irqNow && !flagClear;
            positiveBufferOff <= bufDisable[BIT_POS_BUF_OFF];
            negativeBufferOff <= bufDisable[BIT_NEG_BUF_OFF];
        end
    end

    // pin inputs synchronised; a disabled buffer forces zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            posPinSync1 <= 1'b0;
            posPinSync2 <= 1'b0;
            negPinSync1 <= 1'b0;
            negPinSync2 <= 1'b0;
            positivePinDigital <= 1'b0;
            negativePinDigital <= 1'b0;
        end else begin
            posPinSync1 <= positiveInputPin;
            posPinSync2 <= posPinSync1;
            negPinSync1 <= negativeInputPin;
            negPinSync2 <= negPinSync1;
            positivePinDigital <= posPinSync2 && !bufDisable[BIT_POS_BUF_OFF];
            negativePinDigital <= negPinSync2 && !bufDisable[BIT_NEG_BUF_OFF];
        end
    end

    // ============================================================
    // read data
    wire [7:0] cmpRead = {cmpCtrl[7:6], syncResult, eventFlag, cmpCtrl[3:0]};
    wire [7:0] rdMux = (regBus.rdAddr == ADDR_CMP_CTRL) ? cmpRead
        : (regBus.rdAddr == ADDR_CONV_CTRL_B) ? convCtrlB
        : (regBus.rdAddr == ADDR_BUF_DISABLE) ? bufDisable
        : (regBus.rdAddr == ADDR_CONV_CTRL_A) ? convCtrlA
        : (regBus.rdAddr == ADDR_GLOBAL) ? {7'h00, globalIrqEnable}
        : 8'h00;
    wire rdBad = regBus.rdAddr > ADDR_VECTOR_ACK || regBus.rdAddr[1:0] != 2'b00;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (regBus.rdEn) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rdMux};
            s_axi_rresp <= rdBad ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ============================================================
    // checks
    sequence selRise;
        syncResult && !prevResult && modeSel == MODE_RISE;
    endsequence
    sequence selFall;
        !syncResult && prevResult && modeSel == MODE_FALL;
    endsequence

    chk_sync_two_stage: assert property (@(posedge sys_clk) disable iff (rst)
        syncResult == $past(comparatorRaw, 2) || $past(rst, 2))
        else $error("result does not follow input by two cycles");
    chk_reserved_no_event: assert property (@(posedge sys_clk) disable iff (rst)
        modeSel == MODE_RESERVED && !eventFlag |=> !eventFlag)
        else $error("reserved mode set the flag");
    chk_rise_sets_flag: assert property (@(posedge sys_clk) disable iff (rst)
        selRise |=> eventFlag)
        else $error("rising edge lost");
    chk_fall_sets_flag: assert property (@(posedge sys_clk) disable iff (rst)
        selFall |=> eventFlag)
        else $error("falling edge lost");
    chk_irq_gating: assert property (@(posedge sys_clk) disable iff (rst)
        comparatorIrq |-> $past(eventFlag && irqEnable && globalIrqEnable))
        else $error("irq without all enables");
    chk_vector_clear: assert property (@(posedge sys_clk) disable iff (rst)
        (wrVector || vectorTaken) && !edgeEvent |=> !eventFlag)
        else $error("vector did not clear flag");
    chk_write_one_clear: assert property (@(posedge sys_clk) disable iff (rst)
        wrCmp && regBus.wrData[BIT_EVENT_FLAG] && !edgeEvent |=> !eventFlag)
        else $error("write one did not clear flag");
    chk_power_follow: assert property (@(posedge sys_clk) disable iff (rst)
        wrCmp |=> ##1 comparatorPowerOff == $past(regBus.wrData[BIT_POWER_OFF], 2))
        else $error("power control not applied");
    chk_mux_route: assert property (@(posedge sys_clk) disable iff (rst)
        convEnable |=> negativeSource == 4'h0)
        else $error("mux used while converter on");
    chk_buffer_zero: assert property (@(posedge sys_clk) disable iff (rst)
        bufDisable[BIT_POS_BUF_OFF] |=> !positivePinDigital)
        else $error("disabled buffer read nonzero");
endmodule : ccl_top

// ===== testbench/ccl_analog_model.sv
// partner model: analog levels at the comparator pins and the timer capture front end
`timescale 1ns/100ps
module ccl_analog_model (
    // controls from the block
    input wire logic comparatorPowerOff,
    input wire logic bandgapSelect,
    input wire logic [3:0] negativeSource,
    input wire logic captureInput,
    // analog decision and pin levels
    output logic comparatorRaw,
    output logic positiveInputPin,
    output logic negativeInputPin
);
    // millivolt levels, moved by the bench through hierarchy
    int posMv = 0;
    int negMv = 100;
    int bgMv = 1100;
    int chMv [8] = '{default: 2000};
    int captureEdges = 0;
    int plusMv;
    int minusMv;
    // source selection as the analog front end sees it
    always_comb begin
        plusMv = bandgapSelect ? bgMv : posMv;
        minusMv = negativeSource[3] ? chMv[negativeSource[2:0]] : negMv;
    end
    // an unpowered comparator makes no decision, so its output sits low
    // levels settle 1 ns after a change, never on the clock edge itself
    assign #1 comparatorRaw = !comparatorPowerOff && (plusMv > minusMv);
    assign #1 positiveInputPin = posMv > 1500;
    assign #1 negativeInputPin = negMv > 1500;
    // timer side counts capture triggers as if its capture irq were enabled
    always @(posedge captureInput) begin
        captureEdges++;
    end
endmodule : ccl_analog_model

// ===== testbench/comparator_control_logic_tb.sv
// testbench: register-level tests of the comparator control block
`timescale 1ns/100ps
module comparator_control_logic_tb;
    import ccl_pkg::*;
    // clock, reset and bus
    logic sysClk, rst, awvalid, wvalid, bready, arvalid, rready, vectorTaken;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, lastResp, mode;
    // analog side
    logic comparatorRaw, comparatorPowerOff, bandgapSelect, converterEnable;
    logic converterPowerReduction, positiveInputPin, negativeInputPin, captureInput;
    logic positivePinDigital, negativePinDigital, positiveBufferOff, negativeBufferOff;
    logic comparatorIrq;
    logic [3:0] negativeSource;
    logic [31:0] d;
    int nMismatch = 0;
    int totalChecks = 0;
    int edges;

    ccl_top uut (.sys_clk(sysClk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .comparatorRaw(comparatorRaw), .comparatorPowerOff(comparatorPowerOff),
        .bandgapSelect(bandgapSelect), .negativeSource(negativeSource),
        .converterEnable(converterEnable), .converterPowerReduction(converterPowerReduction),
        .positiveInputPin(positiveInputPin), .negativeInputPin(negativeInputPin),
        .positivePinDigital(positivePinDigital), .negativePinDigital(negativePinDigital),
        .positiveBufferOff(positiveBufferOff), .negativeBufferOff(negativeBufferOff),
        .captureInput(captureInput), .comparatorIrq(comparatorIrq), .vectorTaken(vectorTaken));

    ccl_analog_model pm (.comparatorPowerOff(comparatorPowerOff),
        .bandgapSelect(bandgapSelect), .negativeSource(negativeSource),
        .captureInput(captureInput), .comparatorRaw(comparatorRaw),
        .positiveInputPin(positiveInputPin), .negativeInputPin(negativeInputPin));

    // ============================================================
    // clock and bus tasks
    always #5 sysClk = ~sysClk;

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // a leading edge keeps bready from being lowered and raised in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic awHit, wHit, bHit;
        logic [1:0] resp;
        @(posedge sysClk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h00_0000, v};
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge sysClk);
            awHit = awvalid && awready;
            wHit = wvalid && wready;
            bHit = bvalid === 1'b1;
            resp = bresp;
            @(posedge sysClk);
            if (awHit) awvalid <= 1'b0;
            if (wHit) wvalid <= 1'b0;
        end while (!bHit);
        lastResp = resp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        logic arHit, rHit;
        @(posedge sysClk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge sysClk);
            arHit = arvalid && arready;
            rHit = rvalid === 1'b1;
            v = rdata;
            lastResp = rresp;
            @(posedge sysClk);
            if (arHit) arvalid <= 1'b0;
        end while (!rHit);
        rready <= 1'b0;
    endtask : rd

    task automatic rdChk(input string name, input logic [7:0] a, input logic [7:0] m,
            input logic [7:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(name, v & {24'h00_0000, m}, {24'h00_0000, exp});
    endtask : rdChk

    // long enough for synchroniser, flag and irq stages to land
    task automatic settle();
        repeat (6) @(posedge sysClk);
        #1;
    endtask : settle

    task automatic endSim();
        if (nMismatch == 0 && totalChecks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : endSim

    // ============================================================
    // watchdog
    initial begin
        repeat (20000) @(posedge sysClk);
        nMismatch++;
        endSim();
    end

    // ============================================================
    // tests
    initial begin
        sysClk = 0; rst = 1; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hF; vectorTaken = 0;
        repeat (16) @(posedge sysClk);
        rst <= 1'b0;
        settle();
        rdChk("ctrl reset", ADDR_CMP_CTRL, 8'hFF, RST_CMP_CTRL);
        rdChk("convB reset", ADDR_CONV_CTRL_B, 8'hFF, RST_CONV_CTRL_B);
        rdChk("bufdis reset", ADDR_BUF_DISABLE, 8'hFF, RST_BUF_DISABLE);
        rd(8'h1C, d);
        chk("unmapped rresp", lastResp, RESP_SLVERR);
        wr(8'h1C, 8'h00);
        chk("unmapped bresp", lastResp, RESP_SLVERR);
        // every event mode against a rise then a fall, irq kept off
        for (int m = 0; m < 4; m++) begin
            mode = m[1:0];
            wr(ADDR_CMP_CTRL, {6'h00, mode} | 8'h10);
            pm.posMv = 1000;
            settle();
            rdChk("result high", ADDR_CMP_CTRL, 8'h20, 8'h20);
            rdChk("flag rise", ADDR_CMP_CTRL, 8'h10,
                (mode == MODE_TOGGLE || mode == MODE_RISE) ? 8'h10 : 8'h00);
            wr(ADDR_CMP_CTRL, {6'h00, mode});
            rdChk("flag kept", ADDR_CMP_CTRL, 8'h10,
                (mode == MODE_TOGGLE || mode == MODE_RISE) ? 8'h10 : 8'h00);
            wr(ADDR_CMP_CTRL, {6'h00, mode} | 8'h10);
            rdChk("flag cleared", ADDR_CMP_CTRL, 8'h10, 8'h00);
            pm.posMv = 0;
            settle();
            rdChk("flag fall", ADDR_CMP_CTRL, 8'h30,
                (mode == MODE_TOGGLE || mode == MODE_FALL) ? 8'h10 : 8'h00);
        end
        // interrupt gating, rising mode
        wr(ADDR_GLOBAL, 8'h01);
        wr(ADDR_CMP_CTRL, 8'h1B);
        settle();
        chk("irq idle", comparatorIrq, 1'b0);
        pm.posMv = 1000;
        settle();
        chk("irq on", comparatorIrq, 1'b1);
        wr(ADDR_CMP_CTRL, 8'h03);
        settle();
        chk("irq masked", comparatorIrq, 1'b0);
        rdChk("flag held", ADDR_CMP_CTRL, 8'h10, 8'h10);
        wr(ADDR_CMP_CTRL, 8'h0B);
        wr(ADDR_GLOBAL, 8'h00);
        settle();
        chk("irq global off", comparatorIrq, 1'b0);
        wr(ADDR_GLOBAL, 8'h01);
        settle();
        chk("irq global on", comparatorIrq, 1'b1);
        wr(ADDR_VECTOR_ACK, 8'h00);
        settle();
        chk("irq vectored", comparatorIrq, 1'b0);
        rdChk("flag vectored", ADDR_CMP_CTRL, 8'h10, 8'h00);
        // the processor's vector pulse clears the flag too, toggle mode this time
        wr(ADDR_CMP_CTRL, 8'h03);
        wr(ADDR_CMP_CTRL, 8'h00);
        pm.posMv = 0;
        wr(ADDR_CMP_CTRL, 8'h08);
        settle();
        chk("irq toggle", comparatorIrq, 1'b1);
        @(posedge sysClk);
        vectorTaken <= 1'b1;
        @(posedge sysClk);
        vectorTaken <= 1'b0;
        settle();
        chk("irq pin vector", comparatorIrq, 1'b0);
        rdChk("flag pin vector", ADDR_CMP_CTRL, 8'h10, 8'h00);
        // power, capture route and bandgap, irq disabled before each change
        wr(ADDR_CMP_CTRL, 8'h03);
        pm.posMv = 1000;
        wr(ADDR_CMP_CTRL, 8'h87);
        settle();
        chk("power off", comparatorPowerOff, 1'b1);
        rdChk("result unpowered", ADDR_CMP_CTRL, 8'h20, 8'h00);
        edges = pm.captureEdges;
        wr(ADDR_CMP_CTRL, 8'h07);
        settle();
        chk("capture on", captureInput, 1'b1);
        chk("capture edges", pm.captureEdges, edges + 1);
        wr(ADDR_CMP_CTRL, 8'h03);
        settle();
        chk("capture off", captureInput, 1'b0);
        pm.posMv = 0;
        wr(ADDR_CMP_CTRL, 8'h43);
        settle();
        chk("bandgap", bandgapSelect, 1'b1);
        rdChk("result bandgap", ADDR_CMP_CTRL, 8'h20, 8'h20);
        // negative input multiplexer, then converter enable and power reduction set together
        pm.posMv = 1000;
        wr(ADDR_CMP_CTRL, 8'h03);
        wr(ADDR_CONV_CTRL_B, 8'h40);
        for (int n = 0; n < 8; n++) begin
            wr(ADDR_CONV_CTRL_A, n[7:0]);
            settle();
            chk("neg source", negativeSource, {1'b1, n[2:0]});
        end
        rdChk("result mux", ADDR_CMP_CTRL, 8'h20, 8'h00);
        wr(ADDR_CONV_CTRL_A, 8'hC7);
        settle();
        chk("neg source conv on", negativeSource, 4'h0);
        chk("conv enable", converterEnable, 1'b1);
        chk("power reduction", converterPowerReduction, 1'b1);
        wr(ADDR_CONV_CTRL_A, 8'h07);
        wr(ADDR_CONV_CTRL_B, 8'h00);
        settle();
        chk("neg source mux off", negativeSource, 4'h0);
        // digital buffers on the analog pins
        pm.posMv = 2000;
        pm.negMv = 2000;
        for (int b = 0; b < 3; b++) begin
            wr(ADDR_BUF_DISABLE, b[7:0]);
            settle();
            chk("pos buffer off", positiveBufferOff, b[0]);
            chk("neg buffer off", negativeBufferOff, b[1]);
            chk("pos digital", positivePinDigital, !b[0]);
            chk("neg digital", negativePinDigital, !b[1]);
        end
        endSim();
    end
endmodule : comparator_control_logic_tb
